// ==== design/qdl_pkg.sv ====
// Purpose: Shared constants and types for the quad converter serial loader.
// Assumes: Sixteen-bit command words, channel select first, MSB first.
// Notes: Field positions are bit indices of the assembled command word.
package qdl_pkg;
   // Number of bits in one command word.
   localparam int unsigned QDL_WORD_BITS = 16;
   // Width of the frame bit counter.
   localparam int unsigned QDL_CNT_W = 5;
   // Count value that marks the final bit of a frame.
   localparam logic [4:0] QDL_LAST_CNT = 5'h0f;
   // Count value once a frame is complete.
   localparam logic [4:0] QDL_DONE_CNT = 5'h10;
   // Channel select field, top two bits.
   localparam int unsigned QDL_SEL_HI = 15;
   localparam int unsigned QDL_SEL_LO = 14;
   // Operation code field.
   localparam int unsigned QDL_OP_HI = 13;
   localparam int unsigned QDL_OP_LO = 12;
   // Channel code is the upper ten bits of the twelve-bit data field.
   localparam int unsigned QDL_CODE_HI = 11;
   localparam int unsigned QDL_CODE_LO = 2;
   // Channel code width and channel count.
   localparam int unsigned QDL_CODE_W = 10;
   localparam int unsigned QDL_NUM_CH = 4;
   // Reset value of each channel code.
   localparam logic [9:0] QDL_CODE_RST = 10'h000;
   // Operation codes.
   typedef enum logic [1:0] {
      QDL_OP_WR_NOUPD = 2'h0,
      QDL_OP_WR_UPD = 2'h1,
      QDL_OP_WR_ALL = 2'h2,
      QDL_OP_PWR_DN = 2'h3
   } qdl_op_e;
   // Output termination selections while powered down.
   typedef enum logic [1:0] {
      QDL_TERM_NONE = 2'h0,
      QDL_TERM_HIZ = 2'h1,
      QDL_TERM_LOW_R = 2'h2,
      QDL_TERM_HIGH_R = 2'h3
   } qdl_term_e;
endpackage

// ==== design/qdl_sync.sv ====
// Purpose: Two-flop synchroniser for one level from outside the clock domain.
// Assumes: Input may change at any time relative to clk.
// Notes: Only the second flop is visible to other logic.
`timescale 1ns/100ps
`default_nettype none
module qdl_sync
   import qdl_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Raw input and synchronised copy.
   input wire logic async_in,
   output logic sync_out
);
   // First stage, read only by the second stage.
   logic meta_r;

   // Two flops in series to settle metastability.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== design/qdl_loader.sv ====
// Purpose: Serial command loader and channel registers of a quad converter.
// Assumes: Serial clock is slow enough to be sampled by clk (64 ns period).
// Notes: Analog parts are represented only by their control outputs.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Shift data in on falling serial edges
// - Sixteenth falling edge executes the command
// - Extra clocks after sixteenth edge ignored
// - First two bits select channel
// - Third and fourth bits are operation
// - Last twelve bits data, MSB first
// - Channel code 0 to 1023 straight binary
// - Early select rise discards the frame
// - Power-up clears registers, outputs zero
// - Operation 11 powers down all channels
// - Select bits choose power-down termination
// - Power-down disables bias, amps, strings
// - Power-down keeps channel registers
// - Valid write frame leaves power-down
module qdl_loader
   import qdl_pkg::*;
#(
   parameter int unsigned CODE_W = QDL_CODE_W
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Serial link pins.
   input wire logic frame_sel_b,
   input wire logic ser_clk,
   input wire logic ser_din,
   // Output codes applied to the four channels.
   output logic [CODE_W-1:0] out_code_a,
   output logic [CODE_W-1:0] out_code_b,
   output logic [CODE_W-1:0] out_code_c,
   output logic [CODE_W-1:0] out_code_d,
   // Power-down controls.
   output logic bias_en,
   output logic amp_en,
   output logic string_en,
   output logic [1:0] out_term,
   // Pulses once per executed command.
   output logic cmd_done
);
   // Synchronised link levels.
   logic sel_b_s;
   logic sclk_s;
   logic din_s;
   // Previous serial clock level, for edge detection.
   logic sclk_d_r;
   // Falling serial clock edge seen this cycle.
   logic sclk_fall;
   // Input shift register and bit count.
   logic [QDL_WORD_BITS-1:0] shift_r;
   logic [QDL_CNT_W-1:0] cnt_r;
   // Word just completed, valid when exec is high.
   logic [QDL_WORD_BITS-1:0] word;
   logic exec;
   // Input (holding) registers and output (DAC) registers.
   logic [CODE_W-1:0] hold_r [QDL_NUM_CH];
   logic [CODE_W-1:0] dac_r [QDL_NUM_CH];
   // Power-down state.
   logic pd_r;

   // Synchronisers for the three link pins; select idles high.
   qdl_sync #(.RST_VAL(1'b1)) u_sync_sel
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(frame_sel_b),
      .sync_out(sel_b_s)
   );
   qdl_sync #(.RST_VAL(1'b0)) u_sync_clk
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(ser_clk),
      .sync_out(sclk_s)
   );
   qdl_sync #(.RST_VAL(1'b0)) u_sync_din
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(ser_din),
      .sync_out(din_s)
   );

   // Decode a channel index from the select field.
   function automatic logic [1:0] chan_of(input logic [15:0] w);
      chan_of = w[QDL_SEL_HI:QDL_SEL_LO];
   endfunction

   // Delay the synchronised clock to find its falling edge.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclk_d_r <= 1'b0;
      end
      else
      begin
         sclk_d_r <= sclk_s;
      end
   end

   assign sclk_fall = sclk_d_r && !sclk_s;
   // The sixteenth bit completes the word while select is low.
   assign exec = sclk_fall && !sel_b_s && (cnt_r == QDL_LAST_CNT);
   assign word = {shift_r[QDL_WORD_BITS-2:0], din_s};

   // Shift register and bit counter for the current frame.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_r <= '0;
         cnt_r <= '0;
      end
      else if (sel_b_s)
      begin
         // Select high ends the frame; a partial word is dropped.
         cnt_r <= '0;
      end
      else if (sclk_fall && cnt_r != QDL_DONE_CNT)
      begin
         // Sample data MSB first, stopping after the full word.
         shift_r <= word;
         cnt_r <= cnt_r + 5'h01;
      end
   end

   // Holding registers: one channel or all four are written.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < QDL_NUM_CH; i++)
         begin
            hold_r[i] <= QDL_CODE_RST;
         end
      end
      else if (exec)
      begin
         for (int i = 0; i < QDL_NUM_CH; i++)
         begin
            // Write-all, or the addressed channel none on power-down.
            if (qdl_op_e'(word[QDL_OP_HI:QDL_OP_LO]) == QDL_OP_WR_ALL ||
                (qdl_op_e'(word[QDL_OP_HI:QDL_OP_LO]) != QDL_OP_PWR_DN &&
                 chan_of(word) == 2'(i)))
            begin
               hold_r[i] <= word[QDL_CODE_HI:QDL_CODE_LO];
            end
         end
      end
   end

   // Output registers follow the holding registers on an update.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < QDL_NUM_CH; i++)
         begin
            dac_r[i] <= QDL_CODE_RST;
         end
      end
      else if (exec)
      begin
         for (int i = 0; i < QDL_NUM_CH; i++)
         begin
            // Update uses the fresh word for a channel written now.
            if (qdl_op_e'(word[QDL_OP_HI:QDL_OP_LO]) == QDL_OP_WR_ALL)
            begin
               dac_r[i] <= word[QDL_CODE_HI:QDL_CODE_LO];
            end
            else if (qdl_op_e'(word[QDL_OP_HI:QDL_OP_LO]) == QDL_OP_WR_UPD)
            begin
               dac_r[i] <= (chan_of(word) == 2'(i)) ?
                  word[QDL_CODE_HI:QDL_CODE_LO] : hold_r[i];
            end
         end
      end
   end

   // Power-down state and termination choice.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pd_r <= 1'b0;
         out_term <= QDL_TERM_NONE;
      end
      else if (exec)
      begin
         if (qdl_op_e'(word[QDL_OP_HI:QDL_OP_LO]) == QDL_OP_PWR_DN)
         begin
            pd_r <= 1'b1;
            // Termination from the select bits.
            unique case (chan_of(word))
               2'h1: out_term <= QDL_TERM_LOW_R;
               2'h2: out_term <= QDL_TERM_HIGH_R;
               default: out_term <= QDL_TERM_HIZ;
            endcase
         end
         else
         begin
            // Any write command wakes the outputs.
            pd_r <= 1'b0;
            out_term <= QDL_TERM_NONE;
         end
      end
   end

   // Analog enables and command pulse, registered.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bias_en <= 1'b1;
         amp_en <= 1'b1;
         string_en <= 1'b1;
         cmd_done <= 1'b0;
      end
      else
      begin
         bias_en <= !pd_r;
         amp_en <= !pd_r;
         string_en <= !pd_r;
         cmd_done <= exec;
      end
   end

   // Channel codes as seen on the outputs.
   assign out_code_a = dac_r[0];
   assign out_code_b = dac_r[1];
   assign out_code_c = dac_r[2];
   assign out_code_d = dac_r[3];

   // An early select rise never changes an output register.
   a_abort_keeps: assert property (@(posedge clk) disable iff (!rst_b)
      !cmd_done |-> $stable(dac_r[0]) && $stable(dac_r[1]) &&
      $stable(dac_r[2]) && $stable(dac_r[3]))
      else $error("Output code changed without a command.");
   // Power-down command sets power-down state next cycle.
   a_pd_enter: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h3 |=> pd_r)
      else $error("Power-down command not taken.");
   // A write command clears power-down.
   a_pd_exit: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] != 2'h3 |=> !pd_r)
      else $error("Write command did not wake outputs.");
   // Enables follow power-down with one cycle of delay.
   a_pd_enables: assert property (@(posedge clk) disable iff (!rst_b)
      pd_r ##1 pd_r |-> !bias_en && !amp_en && !string_en)
      else $error("Analog blocks enabled while powered down.");
   // Power-down leaves every holding register alone.
   a_pd_hold: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h3 |=>
      $stable(hold_r[0]) && $stable(hold_r[1]) &&
      $stable(hold_r[2]) && $stable(hold_r[3]))
      else $error("Power-down altered a channel register.");
   // Execution happens only on the sixteenth bit.
   a_exec_count: assert property (@(posedge clk) disable iff (!rst_b)
      exec |=> cnt_r == QDL_DONE_CNT)
      else $error("Command executed on wrong bit.");
   // Each executed command gives one pulse on the done output.
   a_done_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      exec |=> cmd_done)
      else $error("Executed command gave no done pulse.");
   // No further shifting after sixteen bits.
   a_post_ignore: assert property (@(posedge clk) disable iff (!rst_b)
      cnt_r == QDL_DONE_CNT && !sel_b_s |=> $stable(shift_r))
      else $error("Bits shifted after the word was complete.");
   // Select high clears the bit count.
   a_frame_reset: assert property (@(posedge clk) disable iff (!rst_b)
      sel_b_s |=> cnt_r == 5'h00)
      else $error("Bit count kept across frames.");
   // A write without update leaves every output code alone.
   a_noupd_keeps: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h0 |=>
      $stable(dac_r[0]) && $stable(dac_r[1]) &&
      $stable(dac_r[2]) && $stable(dac_r[3]))
      else $error("Write without update changed an output code.");
   // Select bits 01 pick the low-value pull-down in power-down.
   a_term_low: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h3 &&
      word[QDL_SEL_HI:QDL_SEL_LO] == 2'h1 |=> out_term == 2'h2)
      else $error("Wrong termination for select 01.");
   // Select bits 10 pick the high-value pull-down in power-down.
   a_term_high: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h3 &&
      word[QDL_SEL_HI:QDL_SEL_LO] == 2'h2 |=> out_term == 2'h3)
      else $error("Wrong termination for select 10.");
   // Write-all-update puts the code on channel D.
   a_write_all: assert property (@(posedge clk) disable iff (!rst_b)
      exec && word[QDL_OP_HI:QDL_OP_LO] == 2'h2 |=>
      dac_r[3] == $past(word[QDL_CODE_HI:QDL_CODE_LO]))
      else $error("Write-all did not load channel D.");
endmodule
`default_nettype wire

// ==== dv/qdl_host.sv ====
// Purpose: Host serial master model driving the loader's three-wire link.
// Assumes: Link clock period 64 ns, stopped low between frames.
// Notes: Bit counts other than 16 give aborted or overlong frames.
`timescale 1ns/100ps
`default_nettype none
module qdl_host
(
   // System clock used to align pin changes.
   input wire logic clk,
   // Link pins.
   output logic frame_sel_b,
   output logic ser_clk,
   output logic ser_din
);
   // Idle with select high, clock stopped and data low.
   initial
   begin
      frame_sel_b = 1'b1;
      ser_clk = 1'b0;
      ser_din = 1'b0;
   end
   // Waits n clk cycles, then steps just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Sends one frame of nb bits, MSB first, then closes it.
   task automatic send(input logic [15:0] w, input int nb);
      int i;
      tick(1);
      frame_sel_b = 1'b0;
      tick(4);
      for (i = 0; i < nb; i++)
      begin
         // Bits past the sixteenth toggle so any capture would show.
         ser_din = (i < 16) ? w[15 - i] : ~ser_din;
         ser_clk = 1'b1;
         tick(4);
         ser_clk = 1'b0;
         tick(4);
      end
      frame_sel_b = 1'b1;
      ser_din = 1'b0;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ==== dv/qdl_loader_tb.sv ====
// Purpose: Self-checking bench for the quad converter serial loader.
// Assumes: Outputs settle within the host's closing gap after a frame.
// Notes: Expected codes come from a small reference model kept here.
`timescale 1ns/100ps
`default_nettype none
module qdl_loader_tb;
   import qdl_pkg::*;
   logic clk; // System clock.
   logic rst_b; // Active-low reset.
   logic frame_sel_b; // Link select.
   logic ser_clk; // Link clock.
   logic ser_din; // Link data.
   logic [9:0] code_a, code_b, code_c, code_d; // Channel output codes.
   logic bias_en, amp_en, string_en, cmd_done; // Control outputs.
   logic [1:0] out_term; // Termination select.
   logic [9:0] hold_m [4]; // Expected holding codes.
   logic [9:0] out_m [4]; // Expected output codes.
   logic pd_m; // Expected power-down state.
   logic [1:0] term_m; // Expected termination.
   int done_n = 0; // Command pulses seen.
   int done_m = 0; // Command pulses expected.
   int failures = 0;
   int tests_run = 0;
   int i;

   // Free-running 125 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   qdl_loader u_qdl_loader (.clk(clk), .rst_b(rst_b),
      .frame_sel_b(frame_sel_b), .ser_clk(ser_clk), .ser_din(ser_din),
      .out_code_a(code_a), .out_code_b(code_b), .out_code_c(code_c),
      .out_code_d(code_d), .bias_en(bias_en), .amp_en(amp_en),
      .string_en(string_en), .out_term(out_term), .cmd_done(cmd_done));

   qdl_host u_qdl_host (.clk(clk), .frame_sel_b(frame_sel_b),
      .ser_clk(ser_clk), .ser_din(ser_din));

   // Counts executed-command pulses.
   always @(posedge clk)
   begin
      if (cmd_done === 1'b1)
         done_n <= done_n + 1;
   end

   // Compares one value and reports a mismatch.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compares every output against the reference model.
   task automatic chk_all();
      chk(16'(code_a), 16'(out_m[0]));
      chk(16'(code_b), 16'(out_m[1]));
      chk(16'(code_c), 16'(out_m[2]));
      chk(16'(code_d), 16'(out_m[3]));
      chk(16'({bias_en, amp_en, string_en}), {13'h0, {3{~pd_m}}});
      chk(16'(out_term), 16'(term_m));
      chk(16'(done_n), 16'(done_m));
   endtask

   // Sends one command, updates the model when the frame is whole.
   task automatic cmd(input logic [1:0] ch, input logic [1:0] op,
      input logic [9:0] c, input int nb);
      u_qdl_host.send({ch, op, c, 2'h3}, nb);
      if (nb >= 16)
      begin
         done_m++;
         pd_m = (op == 2'h3);
         term_m = !pd_m ? 2'h0 : (ch == 2'h1) ? 2'h2 : (ch == 2'h2) ? 2'h3 : 2'h1;
         if (op == 2'h0 || op == 2'h1)
            hold_m[ch] = c;
         if (op == 2'h2)
            hold_m = '{c, c, c, c};
         if (op == 2'h1 || op == 2'h2)
            out_m = hold_m;
      end
      chk_all();
   endtask

   // Prints counts and the verdict, then stops.
   task automatic conclude();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Main sequence of commands.
   initial
   begin
      hold_m = '{default: 10'h000};
      out_m = '{default: 10'h000};
      pd_m = 1'b0;
      term_m = 2'h0;
      rst_b = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      chk_all();
      cmd(2'h0, 2'h0, 10'h155, 16);
      cmd(2'h1, 2'h1, 10'h3ff, 16);
      for (i = 0; i < 4; i++)
         cmd(2'(i), 2'h1, 10'(i + 1), 16);
      cmd(2'h2, 2'h2, 10'h201, 16);
      cmd(2'h1, 2'h2, 10'h000, 15);
      // Long enough that a counter which kept running would wrap and fire.
      cmd(2'h2, 2'h1, 10'h001, 48);
      for (i = 0; i < 4; i++)
         cmd(2'(i), 2'h3, 10'h0aa, 16);
      cmd(2'h3, 2'h0, 10'h123, 16);
      cmd(2'h0, 2'h3, 10'h000, 16);
      cmd(2'h1, 2'h1, 10'h042, 16);
      // A second reset mid-run must clear the codes loaded so far.
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      hold_m = '{default: 10'h000};
      out_m = '{default: 10'h000};
      pd_m = 1'b0;
      term_m = 2'h0;
      repeat (3) @(posedge clk);
      #1;
      chk_all();
      cmd(2'h2, 2'h1, 10'h0f0, 16);
      conclude();
   end

   // Cuts a hang short well beyond the expected run time.
   initial
   begin
      #100000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
